// File: src/cfg_pin_pkg.sv
// Purpose: shared constants and types for the configuration pin decoder
// Assumes: one 50 MHz clock, AXI4-Lite register access
// Notes: offsets are byte addresses of aligned 32-bit words
package cfg_pin_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_HOLD = 8'h08;
    // control register fields
    localparam int CTRL_PDN_IGNORE_BIT = 0;
    localparam int CTRL_PINS_OFF_BIT = 1;
    localparam int CTRL_AUTO_SWITCH_BIT = 2;
    localparam int CTRL_SENSE_SEL_BIT = 3;
    localparam int CTRL_RES_LSB = 4;
    localparam int CTRL_CHOP_BIT = 6;
    localparam int CTRL_PDN_EN_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [4:0] HOLD_RESET = 5'h00;
    localparam int HOLD_W = 5;
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // microstep codes, pattern is {second, first}
    localparam logic [6:0] STEPS_CODE_00 = 7'h08;
    localparam logic [6:0] STEPS_CODE_01 = 7'h20;
    localparam logic [6:0] STEPS_CODE_10 = 7'h40;
    localparam logic [6:0] STEPS_CODE_11 = 7'h10;

    typedef enum logic [1:0] {
        CHOP_QUIET = 2'h0,
        CHOP_CYCLE = 2'h1,
        CHOP_AUTO = 2'h3
    } chop_mode_e;

    typedef struct packed {
        logic pdn_pin;
        logic chop_pin;
        logic res_second;
        logic res_first;
        logic enable_not;
    } cfg_pins_s;

    typedef struct packed {
        logic [6:0] microsteps;
        logic [1:0] node_addr;
        chop_mode_e chop_mode;
        logic standstill_pd;
        logic stage_on;
    } cfg_out_s;
endpackage

// File: src/pin_sync.sv
// Purpose: two-stage synchroniser for a bundle of level inputs
// Assumes: inputs are slow static levels
// Notes: first stage is read only by the second stage
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 5
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule
`default_nettype wire

// File: src/config_pin_decoder.sv
// Purpose: decode driver configuration pins, with register override
// Assumes: pins static, AXI4-Lite master keeps one access per channel
// Notes: no interrupts, single clock domain
// Contract
// R01: standstill power-down pin low enables, high disables automatic power-down.
// R02: serial host sets power-down ignore bit, then programs hold current.
// R03: microstep pins 00/01/10/11 select 8/32/64/16 microsteps.
// R04: chopper pin low uses quiet chopper, optionally auto; high uses cycle.
// R05: in serial mode pins can be disabled so registers decide.
// R06: host sets internal sense select before enabling the drivers.
// R07: microstep pins also give serial node address 0 to 3.
// R08: enable-not high switches off the power stage, outputs float.
// R09: every configuration pin passes a two-stage synchroniser first.
`timescale 1ns/1ns
`default_nettype none
module config_pin_decoder (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire cfg_pin_pkg::cfg_pins_s pins_i,
    output cfg_pin_pkg::cfg_out_s cfg_o,
    output logic internal_sense_o,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import cfg_pin_pkg::*;

    // ************************************************
    // pin synchronisation
    // ************************************************
    cfg_pins_s pins_s;

    pin_sync #(.WIDTH($bits(cfg_pins_s))) u_sync ( // R09
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .async_i(pins_i),
        .sync_o(pins_s)
    );

    // ************************************************
    // register file
    // ************************************************
    logic [7:0] ctrl_q;
    logic [HOLD_W-1:0] hold_q;
    logic [7:0] aw_addr_q;
    logic aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_have_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_have_q && w_have_q && !bvalid_q;
    wire wr_ctrl = do_write && (aw_addr_q[7:2] == OFS_CTRL[7:2]);
    wire wr_hold = do_write && (aw_addr_q[7:2] == OFS_HOLD[7:2]);
    wire wr_stat = do_write && (aw_addr_q[7:2] == OFS_STATUS[7:2]);
    wire wr_ok = wr_ctrl || wr_hold || wr_stat;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // only byte 0 carries control and hold fields
    wire [7:0] ctrl_d = (wr_ctrl && w_strb_q[0]) ? w_data_q[7:0] : ctrl_q;
    wire [HOLD_W-1:0] hold_d = (wr_hold && w_strb_q[0]) ?
        w_data_q[HOLD_W-1:0] : hold_q;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= CTRL_RESET;
            hold_q <= HOLD_RESET;
        end else begin
            ctrl_q <= ctrl_d; // R05
            hold_q <= hold_d; // R02
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_have_q <= 1'b0;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ************************************************
    // decode
    // ************************************************
    wire pins_off = ctrl_q[CTRL_PINS_OFF_BIT];
    wire [1:0] res_pins = {pins_s.res_second, pins_s.res_first};
    wire [1:0] res_sel = pins_off ?
        ctrl_q[CTRL_RES_LSB +: 2] : res_pins; // R05
    logic [6:0] steps;

    always_comb begin
        case (res_sel) // R03
            2'b00: steps = STEPS_CODE_00;
            2'b01: steps = STEPS_CODE_01;
            2'b10: steps = STEPS_CODE_10;
            2'b11: steps = STEPS_CODE_11;
            default: steps = STEPS_CODE_00;
        endcase
    end

    wire chop_hi = pins_off ? ctrl_q[CTRL_CHOP_BIT] : pins_s.chop_pin;
    wire auto_sw = ctrl_q[CTRL_AUTO_SWITCH_BIT];
    wire chop_mode_e chop_sel = chop_hi ? CHOP_CYCLE :
        (auto_sw ? CHOP_AUTO : CHOP_QUIET); // R04
    // power-down pin honoured unless the host asked to ignore it
    wire pd_en = ctrl_q[CTRL_PDN_IGNORE_BIT] ?
        ctrl_q[CTRL_PDN_EN_BIT] : !pins_s.pdn_pin; // R01 R02
    wire stage_on = !pins_s.enable_not; // R08

    cfg_out_s cfg_q;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_q <= '0;
        end else begin
            cfg_q.microsteps <= steps;
            cfg_q.node_addr <= res_pins; // R07
            cfg_q.chop_mode <= chop_sel;
            cfg_q.standstill_pd <= pd_en;
            cfg_q.stage_on <= stage_on;
        end
    end

    assign cfg_o = cfg_q;
    assign internal_sense_o = ctrl_q[CTRL_SENSE_SEL_BIT]; // R06

    // ************************************************
    // read path
    // ************************************************
    wire rd_ctrl = s_axi_araddr[7:2] == OFS_CTRL[7:2];
    wire rd_stat = s_axi_araddr[7:2] == OFS_STATUS[7:2];
    wire rd_hold = s_axi_araddr[7:2] == OFS_HOLD[7:2];
    wire [31:0] stat_word = {19'h0, cfg_q.stage_on, cfg_q.standstill_pd,
        cfg_q.chop_mode, cfg_q.node_addr, cfg_q.microsteps};
    wire [31:0] rd_word = rd_ctrl ? {24'h0, ctrl_q} :
        rd_stat ? stat_word :
        rd_hold ? {27'h0, hold_q} : 32'h0000_0000;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= (rd_ctrl || rd_stat || rd_hold) ?
                RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ************************************************
    // assertions
    // ************************************************
    property p_pd_pin;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (resetn_i && !ctrl_q[CTRL_PDN_IGNORE_BIT] && !pins_i.pdn_pin)[*3]
        |=> cfg_o.standstill_pd;
    endproperty
    a_pd_pin: assert property (p_pd_pin) else $error("pd pin ignored"); // R01

    property p_pd_ignore;
        @(posedge core_clk_i) disable iff (!resetn_i)
        ctrl_q[CTRL_PDN_IGNORE_BIT] |=>
        cfg_o.standstill_pd == $past(ctrl_q[CTRL_PDN_EN_BIT]);
    endproperty
    a_pd_ignore: assert property (p_pd_ignore) // R02
        else $error("pd override");

    property p_res;
        @(posedge core_clk_i) disable iff (!resetn_i)
        // synchroniser resets low, so the release edge is not a pin sample
        (resetn_i && !pins_off && pins_i.res_second && !pins_i.res_first)[*3]
        |=> cfg_o.microsteps == STEPS_CODE_10;
    endproperty
    a_res: assert property (p_res) else $error("bad microsteps"); // R03

    property p_chop;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (resetn_i && !pins_off && pins_i.chop_pin)[*3]
        |=> cfg_o.chop_mode == CHOP_CYCLE;
    endproperty
    a_chop: assert property (p_chop) else $error("bad chopper"); // R04

    property p_pins_off;
        @(posedge core_clk_i) disable iff (!resetn_i)
        pins_off[*2] |=> cfg_o.microsteps == STEPS_CODE_10 ||
        $past(ctrl_q[CTRL_RES_LSB +: 2]) != 2'b10;
    endproperty
    a_pins_off: assert property (p_pins_off) else $error("pins not off"); // R05

    property p_sense;
        @(posedge core_clk_i) disable iff (!resetn_i)
        wr_ctrl && w_strb_q[0] |=>
        internal_sense_o == $past(w_data_q[CTRL_SENSE_SEL_BIT]);
    endproperty
    a_sense: assert property (p_sense) else $error("sense select"); // R06

    property p_addr;
        @(posedge core_clk_i) disable iff (!resetn_i)
        resetn_i |-> ##3 cfg_o.node_addr ==
        $past({pins_i.res_second, pins_i.res_first}, 3);
    endproperty
    a_addr: assert property (p_addr) else $error("bad node addr"); // R07

    property p_stage;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (resetn_i && pins_i.enable_not)[*3] |=> !cfg_o.stage_on;
    endproperty
    a_stage: assert property (p_stage) else $error("stage not off"); // R08

    property p_sync;
        @(posedge core_clk_i) disable iff (!resetn_i)
        $rose(pins_i.enable_not) ##1 pins_i.enable_not |=>
        $past(cfg_o.stage_on) == cfg_o.stage_on ##1 !cfg_o.stage_on;
    endproperty
    a_sync: assert property (p_sync) else $error("sync depth"); // R09

    property p_pins_chop;
        @(posedge core_clk_i) disable iff (!resetn_i)
        pins_off && ctrl_q[CTRL_CHOP_BIT] |=>
        cfg_o.chop_mode == CHOP_CYCLE;
    endproperty
    a_pins_chop: assert property (p_pins_chop) else $error("chop reg"); // R05

    property p_auto;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (resetn_i && !pins_off && !pins_i.chop_pin)[*3] ##0 auto_sw
        |=> cfg_o.chop_mode == CHOP_AUTO;
    endproperty
    a_auto: assert property (p_auto) else $error("no auto switch"); // R04

    property p_stage_on;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (resetn_i && !pins_i.enable_not)[*3] |=> cfg_o.stage_on;
    endproperty
    a_stage_on: assert property (p_stage_on) else $error("stage off"); // R08

    property p_hold;
        @(posedge core_clk_i) disable iff (!resetn_i)
        wr_hold && w_strb_q[0] |=> hold_q == $past(w_data_q[HOLD_W-1:0]);
    endproperty
    a_hold: assert property (p_hold) else $error("hold not stored"); // R02

    property p_rd_err;
        @(posedge core_clk_i) disable iff (!resetn_i)
        ar_take && !(rd_ctrl || rd_stat || rd_hold) |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("unmapped read"); // unmapped read answers SLVERR with zero data

    c_write: cover property (@(posedge core_clk_i) bvalid_q && s_axi_bready);
    c_read: cover property (@(posedge core_clk_i) rvalid_q && s_axi_rready);
    c_auto: cover property (@(posedge core_clk_i)
        cfg_o.chop_mode == CHOP_AUTO);
    c_pins_off: cover property (@(posedge core_clk_i)
        pins_off && cfg_o.chop_mode == CHOP_CYCLE);
    c_slverr: cover property (@(posedge core_clk_i)
        bvalid_q && bresp_q == RESP_SLVERR);
endmodule
`default_nettype wire

// File: tb/strap_board.sv
// Purpose: board strap levels seen by the decoder pins
// Assumes: the bench sets levels and which straps are left open
// Notes: straps with a pull-down read low when open
`timescale 1ns/1ns
`default_nettype none
module strap_board (
    input wire cfg_pin_pkg::cfg_pins_s level_i,
    input wire logic [2:0] open_i,
    output cfg_pin_pkg::cfg_pins_s pins_o
);
    import cfg_pin_pkg::*;
    // ****************
    // strap resolution
    // ****************
    // an open strap falls to its pull-down, never keeps its old level
    // one driver for the whole struct, fields in declaration order
    assign pins_o = {level_i.pdn_pin,
        level_i.chop_pin & ~open_i[2],
        level_i.res_second & ~open_i[1],
        level_i.res_first & ~open_i[0],
        level_i.enable_not};
endmodule
`default_nettype wire

// File: tb/config_pin_decoder_tb_top.sv
// Purpose: self-checking bench for the configuration pin decoder
// Assumes: 50 MHz clock, straps driven through the board model
// Notes: pin cases from a table, register cases by hand
`timescale 1ns/1ns
`default_nettype none
module config_pin_decoder_tb_top;
    import cfg_pin_pkg::*;
    logic core_clk_i = 1'h0;
    logic resetn_i = 1'h0;
    cfg_pins_s straps = '0;
    logic [2:0] strap_open = '0;
    cfg_pins_s pins;
    cfg_out_s cfg;
    logic isense;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    int fails = 0;
    int n_tests = 0;
    logic [17:0] rows [5];

    always #10 core_clk_i = ~core_clk_i;

    strap_board u_strap_board (.level_i(straps), .open_i(strap_open),
        .pins_o(pins));
    config_pin_decoder u_config_pin_decoder (.core_clk_i(core_clk_i),
        .resetn_i(resetn_i), .pins_i(pins), .cfg_o(cfg),
        .internal_sense_o(isense), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    // *****************
    // compares and bus
    // *****************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_cfg(input logic [12:0] e);
        n_tests++;
        if (cfg !== e) begin
            fails++;
            $display("Error cfg_o expected %0h seen %0h", e, cfg);
        end
    endtask
    // register effects have no fixed latency, so wait boundedly
    task automatic wait_cfg(input logic [12:0] e);
        for (int i = 0; i < 8 && cfg !== e; i++) @(posedge core_clk_i);
        #1 chk_cfg(e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge core_clk_i);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (int i = 0; i < 100; i++) begin
            @(posedge core_clk_i);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge core_clk_i);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (int i = 0; i < 100; i++) begin
            @(posedge core_clk_i);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'h0;
    endtask
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk_i);
        fails++;
        print_verdict();
    end

    // ***********
    // main flow
    // ***********
    initial begin
        // pins {pdn, chop, second, first, enable_not}, then cfg_o
        rows = '{{5'h00, STEPS_CODE_00, 2'h0, CHOP_QUIET, 2'h3},
                 {5'h12, STEPS_CODE_01, 2'h1, CHOP_QUIET, 2'h1},
                 {5'h0C, STEPS_CODE_10, 2'h2, CHOP_CYCLE, 2'h3},
                 {5'h1F, STEPS_CODE_11, 2'h3, CHOP_CYCLE, 2'h0},
                 {5'h07, STEPS_CODE_11, 2'h3, CHOP_QUIET, 2'h2}};
        repeat (12) @(posedge core_clk_i);
        resetn_i <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk_i);
            straps <= rows[i][17:13];
            repeat (2) @(posedge core_clk_i);
            #1 chk_cfg(rows[i == 0 ? 0 : i - 1][12:0]);
            @(posedge core_clk_i);
            #1 chk_cfg(rows[i][12:0]);
        end
        rd_reg(OFS_CTRL);
        chk("ctrl", CTRL_RESET, rd);
        rd_reg(OFS_HOLD);
        chk("hold", HOLD_RESET, rd);
        rd_reg(8'h0C);
        chk("unmapped rdata", 32'h0, rd);
        chk("unmapped rresp", RESP_SLVERR, rs);
        wr(OFS_CTRL, 32'h08, 4'hF);
        #1 chk("isense", 32'h1, isense);
        straps <= 5'h06;
        wait_cfg({STEPS_CODE_11, 2'h3, CHOP_QUIET, 2'h3});
        straps <= 5'h16;
        wr(OFS_CTRL, 32'h89, 4'hF);
        wr(OFS_HOLD, 32'h15, 4'hF);
        rd_reg(OFS_HOLD);
        chk("hold", 32'h15, rd);
        wait_cfg({STEPS_CODE_11, 2'h3, CHOP_QUIET, 2'h3});
        straps <= 5'h06;
        wr(OFS_CTRL, 32'h09, 4'hF);
        wait_cfg({STEPS_CODE_11, 2'h3, CHOP_QUIET, 2'h1});
        wr(OFS_CTRL, 32'h6B, 4'hF);
        wait_cfg({STEPS_CODE_10, 2'h3, CHOP_CYCLE, 2'h1});
        wr(OFS_CTRL, 32'h1F, 4'hF);
        wait_cfg({STEPS_CODE_01, 2'h3, CHOP_AUTO, 2'h1});
        for (int k = 0; k < 2; k++) begin
            rd_reg(OFS_STATUS);
            chk("status", {19'h0, 2'h2, CHOP_AUTO, 2'h3, STEPS_CODE_01},
                rd);
            wr(OFS_STATUS, 32'h0, 4'hF);
            chk("status bresp", RESP_OKAY, rs);
        end
        wr(8'h10, 32'hFF, 4'hF);
        chk("unmapped bresp", RESP_SLVERR, rs);
        wr(OFS_CTRL, 32'h0, 4'h0);
        rd_reg(OFS_CTRL);
        chk("ctrl", 32'h1F, rd);
        wr(OFS_CTRL, 32'h0C, 4'hF);
        wait_cfg({STEPS_CODE_11, 2'h3, CHOP_AUTO, 2'h3});
        straps <= 5'h0E;
        strap_open <= 3'h7;
        wait_cfg({STEPS_CODE_00, 2'h0, CHOP_AUTO, 2'h3});
        strap_open <= 3'h0;
        wait_cfg({STEPS_CODE_11, 2'h3, CHOP_CYCLE, 2'h3});
        @(posedge core_clk_i);
        resetn_i <= 1'h0;
        #1 chk_cfg(13'h0);
        chk("isense", 32'h0, isense);
        repeat (3) @(posedge core_clk_i);
        resetn_i <= 1'h1;
        rd_reg(OFS_CTRL);
        chk("ctrl", CTRL_RESET, rd);
        print_verdict();
    end
endmodule
`default_nettype wire
